// ---- design/osc_select_pkg.sv ----
// Constants, field layouts and carrier types for the oscillator selector.
// Assumes one 250 MHz core clock that samples every oscillator as a level.
package osc_select_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ      = 250;
  localparam int STARTUP_US   = 1000;
  localparam int STARTUP_CYC  = STARTUP_US * CLK_MHZ;
  localparam int STARTUP_W    = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_SYS_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_FRC_CTRL  = 8'h01;
  localparam logic [7:0] ADDR_SXT_CTRL  = 8'h02;
  localparam logic [7:0] ADDR_PIN_CTRL  = 8'h03;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;

  // system_clock_control_reg fields
  localparam int SEL_LSB      = 5;
  localparam int HSS_BIT      = 3;
  localparam int LSS_BIT      = 2;
  localparam int FH_IDLE_BIT  = 1;
  localparam int FS_IDLE_BIT  = 0;

  // Other field positions
  localparam int FRC_MATCH_BIT  = 2;
  localparam int SXT_EN_BIT     = 0;
  localparam int SXT_READY_BIT  = 1;
  localparam int ST_SLOW_BIT    = 0;
  localparam int ST_SWITCH_BIT  = 1;
  localparam int ST_READY_BIT   = 2;
  localparam int ST_HALT_BIT    = 3;

  // Encodings
  localparam logic [2:0] SEL_SLOW   = 3'h7;
  localparam logic       HS_CRYSTAL = 1'b0;
  localparam logic       LS_CRYSTAL = 1'b0;

  // Oscillator input order
  localparam int OSC_FXT = 0;
  localparam int OSC_FRC = 1;
  localparam int OSC_SXT = 2;
  localparam int OSC_SRC = 3;

  // Reset values: fast RC, undivided, slow RC
  localparam logic [2:0] SEL_RST  = 3'h0;
  localparam logic       HSS_RST  = 1'b1;
  localparam logic       LSS_RST  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic {
    SW_RUN  = 1'b0,
    SW_PARK = 1'b1
  } sw_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic sys;
    logic fh;
    logic fsub;
    logic wdt;
    logic tbase;
  } clk_out_t;

endpackage

// ---- design/system_oscillator_select.sv ----
// System clock source selector with glitch-free switching and dividers.
// Assumes oscillators arrive as free-running levels far slower than clk_i,
// and that halt_i comes from logic on clk_i.
//
// Overview of operation
// - The system clock follows the fast or slow source named by sysclk_select and may be changed at any time.
// - The slow source is the slow crystal, once it is ready, or else the slow RC oscillator, per low_speed_source_sel.
// - The fast source is the fast crystal or fast RC oscillator per high_speed_source_sel.
// - The same sysclk_select field sets the delivered system clock rate.
// - One fast and one slow oscillator are always selected; no empty choice exists.
// - The fast RC oscillator runs at 8, 12 or 16 MHz as chosen by a fixed configuration option.
// - With both pin-sharing bits set, writing slow_crystal_enable to 1 starts the slow crystal, which then needs a start-up delay.
// - The oscillators also clock the watchdog and the time base.
// - In sleep or idle the system clock is gated off while a separate clock may keep timers running.
// - Pin-sharing bits decide whether the slow crystal pins serve the oscillator or other functions.
// - In fast mode the fast clock is divided by 1 up to 64 per sysclk_select.
`timescale 1ns/1ns

module system_oscillator_select #(
  parameter int STARTUP_CYCLES = osc_select_pkg::STARTUP_CYC
) (
  // Clock, reset, enable
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire logic                      ce_i,
  // Register port
  input  wire osc_select_pkg::bus_req_t  bus_i,
  output      logic [7:0]                rdata_o,
  // Oscillator levels and configuration option
  input  wire logic [3:0]                osc_i,
  input  wire logic [1:0]                fast_rc_cfg_i,
  input  wire logic                      halt_i,
  // Clock and control outputs
  output      osc_select_pkg::clk_out_t  clocks_o,
  output      logic [1:0]                fast_rc_freq_o,
  output      logic                      slow_crystal_run_o,
  output      logic [1:0]                slow_crystal_pins_osc_o
);
  import osc_select_pkg::*;

  typedef struct packed {
    logic [3:0]           sync1;
    logic [3:0]           sync2;
    logic                 fh_prev;
    logic [5:0]           div_cnt;
    logic [2:0]           sysclk_select;
    logic                 high_speed_source_sel;
    logic                 low_speed_source_sel;
    logic                 fh_idle_en;
    logic                 fs_idle_en;
    logic [1:0]           fast_rc_freq_sel;
    logic [1:0]           rc_cfg;
    logic                 slow_crystal_enable;
    logic [1:0]           pins_osc;
    logic [STARTUP_W-1:0] start_cnt;
    logic                 sxt_ready;
    sw_state_t            sw_state;
    logic [2:0]           cur_sel;
    logic                 cur_hs;
    logic                 cur_ls_xt;
    logic                 xt_run;
    logic                 sys_gate;
    logic                 fh_gate;
    logic                 fs_gate;
    clk_out_t             clocks;
    logic [7:0]           rdata;
  } state_t;

  localparam state_t STATE_RST = '{
    sysclk_select:         SEL_RST,
    high_speed_source_sel: HSS_RST,
    low_speed_source_sel:  LSS_RST,
    cur_sel:               SEL_RST,
    cur_hs:                HSS_RST,
    sw_state:              SW_RUN,
    sys_gate:              1'b1,
    fh_gate:               1'b1,
    fs_gate:               1'b1,
    default:               '0
  };

  localparam logic [STARTUP_W-1:0] START_LAST =
    STARTUP_W'(STARTUP_CYCLES - 1);

  state_t q;
  state_t d;

  logic       fh_lvl;
  logic       fsub_lvl;
  logic       cur_lvl;
  logic       new_lvl;
  logic       sxt_run;
  logic       fh_on;
  logic       fs_on;
  logic       fh_new;
  logic       fsub_new;
  logic       ls_pick;
  logic       sel_diff;
  logic [7:0] sys_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Level of the clock delivered for a given select value
  function automatic logic sel_level(input logic [2:0] sel,
                                     input logic       fh,
                                     input logic       fsub,
                                     input logic [5:0] cnt);
    logic lvl;
    lvl = fh;
    if (sel == SEL_SLOW) begin
      lvl = fsub;
    end else if (sel != 3'h0) begin
      lvl = cnt[sel - 3'h1];
    end
    return lvl;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d        = q;
    fh_lvl   = 1'b0;
    fsub_lvl = 1'b0;
    cur_lvl  = 1'b0;
    new_lvl  = 1'b0;
    sxt_run  = 1'b0;
    fh_on    = 1'b0;
    fs_on    = 1'b0;
    fh_new   = 1'b0;
    fsub_new = 1'b0;
    ls_pick  = 1'b0;
    sel_diff = 1'b0;
    sys_reg  = {q.sysclk_select, 1'b0, q.high_speed_source_sel,
                q.low_speed_source_sel, q.fh_idle_en, q.fs_idle_en};
    if (reset_i) begin
      d = STATE_RST;
      d.rc_cfg = fast_rc_cfg_i;
    end else if (ce_i) begin
      d.sync1 = osc_i;
      d.sync2 = q.sync1;

      // one-bit select
      // Live picks follow the applied selection, new picks the registers
      fh_lvl = (q.cur_hs == HS_CRYSTAL) ? q.sync2[OSC_FXT]
                                        : q.sync2[OSC_FRC];
      fh_new = (q.high_speed_source_sel == HS_CRYSTAL) ? q.sync2[OSC_FXT]
                                                       : q.sync2[OSC_FRC];
      ls_pick  = (q.low_speed_source_sel == LS_CRYSTAL) && q.sxt_ready;
      fsub_lvl = q.cur_ls_xt ? q.sync2[OSC_SXT] : q.sync2[OSC_SRC];
      fsub_new = ls_pick ? q.sync2[OSC_SXT] : q.sync2[OSC_SRC];

      d.fh_prev = fh_lvl;
      if (fh_lvl && !q.fh_prev) begin
        d.div_cnt = q.div_cnt + 6'h01;
      end

      sxt_run = q.slow_crystal_enable && (q.pins_osc == 2'h3);
      if (!sxt_run) begin
        d.start_cnt = '0;
        d.sxt_ready = 1'b0;
      end else if (!q.sxt_ready) begin
        if (q.start_cnt == START_LAST) begin
          d.sxt_ready = 1'b1;
        end else begin
          d.start_cnt = q.start_cnt + STARTUP_W'(1);
        end
      end

      cur_lvl = sel_level(q.cur_sel, fh_lvl, fsub_lvl, q.div_cnt);
      new_lvl = sel_level(q.sysclk_select, fh_new, fsub_new, q.div_cnt);
      sel_diff = {q.sysclk_select, q.high_speed_source_sel, ls_pick} !=
                 {q.cur_sel, q.cur_hs, q.cur_ls_xt};

      // park while low
      // Source bits and crystal readiness also park, so no oscillator
      // swap ever reaches the live path in mid-pulse
      case (q.sw_state)
        SW_RUN: begin
          if (sel_diff && !cur_lvl) begin
            d.sw_state = SW_PARK;
          end
        end
        SW_PARK: begin
          if (!new_lvl) begin
            d.cur_sel   = q.sysclk_select;
            d.cur_hs    = q.high_speed_source_sel;
            d.cur_ls_xt = ls_pick;
            // Restart edge detection on the new fast source
            d.fh_prev   = fh_new;
            d.sw_state  = SW_RUN;
          end
        end
        default: begin
          d.sw_state = SW_RUN;
        end
      endcase

      fh_on = !(halt_i && !q.fh_idle_en);
      fs_on = !(halt_i && !q.fs_idle_en);
      if (!cur_lvl) begin
        d.sys_gate = !halt_i;
      end
      if (!fh_lvl) begin
        d.fh_gate = fh_on;
      end
      if (!fsub_lvl) begin
        d.fs_gate = fs_on;
      end
      d.clocks.sys   = (q.sw_state == SW_RUN) && q.sys_gate && cur_lvl;
      d.clocks.fh    = q.fh_gate && fh_lvl;
      d.clocks.fsub  = q.fs_gate && fsub_lvl;
      d.clocks.wdt   = q.sync2[OSC_SRC];
      d.clocks.tbase = q.fs_gate && fsub_lvl;

      // Register writes
      if (bus_i.wr) begin
        case (bus_i.addr)
          ADDR_SYS_CTRL: begin
            d.sysclk_select         = bus_i.wdata[SEL_LSB +: 3];
            d.high_speed_source_sel = bus_i.wdata[HSS_BIT];
            d.low_speed_source_sel  = bus_i.wdata[LSS_BIT];
            d.fh_idle_en            = bus_i.wdata[FH_IDLE_BIT];
            d.fs_idle_en            = bus_i.wdata[FS_IDLE_BIT];
          end
          ADDR_FRC_CTRL: begin
            d.fast_rc_freq_sel = bus_i.wdata[1:0];
          end
          ADDR_SXT_CTRL: begin
            d.slow_crystal_enable = bus_i.wdata[SXT_EN_BIT];
          end
          ADDR_PIN_CTRL: begin
            d.pins_osc = bus_i.wdata[1:0];
          end
          default: begin
          end
        endcase
      end

      d.xt_run = d.slow_crystal_enable && (d.pins_osc == 2'h3);

      // Register reads, data valid one cycle later only
      d.rdata = 8'h00;
      if (bus_i.rd) begin
        case (bus_i.addr)
          ADDR_SYS_CTRL: begin
            d.rdata = sys_reg;
          end
          ADDR_FRC_CTRL: begin
            d.rdata = {5'h00, q.fast_rc_freq_sel == q.rc_cfg,
                       q.fast_rc_freq_sel};
          end
          ADDR_SXT_CTRL: begin
            d.rdata[SXT_EN_BIT]    = q.slow_crystal_enable;
            d.rdata[SXT_READY_BIT] = q.sxt_ready;
          end
          ADDR_PIN_CTRL: begin
            d.rdata = {6'h00, q.pins_osc};
          end
          ADDR_STATUS: begin
            d.rdata[ST_SLOW_BIT]   = (q.cur_sel == SEL_SLOW);
            d.rdata[ST_SWITCH_BIT] = (q.sw_state == SW_PARK);
            d.rdata[ST_READY_BIT]  = q.sxt_ready;
            d.rdata[ST_HALT_BIT]   = halt_i;
          end
          default: begin
            d.rdata = 8'h00;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata_o                 = q.rdata;
  assign clocks_o                = q.clocks;
  assign fast_rc_freq_o          = q.rc_cfg;
  assign slow_crystal_run_o      = q.xt_run;
  assign slow_crystal_pins_osc_o = q.pins_osc;

endmodule

// ---- testbench/osc_select_sva.sv ----
// Port assertions for the oscillator selector.
// Assumes oscillator half periods of three cycles or more.
`timescale 1ns/1ns

module osc_select_sva
  import osc_select_pkg::*;
(
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       reset_i,
  // Inputs
  input wire bus_req_t   bus_i,
  input wire logic [3:0] osc_i,
  input wire logic [1:0] fast_rc_cfg_i,
  input wire logic       halt_i,
  // Outputs
  input wire logic [7:0] rdata_o,
  input wire clk_out_t   clocks_o,
  input wire logic [1:0] fast_rc_freq_o,
  input wire logic       slow_crystal_run_o,
  input wire logic [1:0] slow_crystal_pins_osc_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_halted;
    halt_i [*8];
  endsequence

  property p_cfg_take;
    $past(reset_i) |-> fast_rc_freq_o == $past(fast_rc_cfg_i);
  endproperty
  property p_cfg_hold;
    !$past(reset_i) |-> $stable(fast_rc_freq_o);
  endproperty
  property p_run_pins;
    slow_crystal_run_o |-> &slow_crystal_pins_osc_o;
  endproperty
  property p_halt;
    s_halted ##0 !clocks_o.sys |=> !clocks_o.sys;
  endproperty
  property p_wdt;
    $rose(osc_i[OSC_SRC]) |-> ##[2:8] clocks_o.wdt;
  endproperty
  property p_rise;
    $rose(clocks_o.sys) |=> clocks_o.sys;
  endproperty
  property p_fall;
    $fell(clocks_o.sys) |=> !clocks_o.sys;
  endproperty
  property p_rdata;
    !$past(bus_i.rd) |-> rdata_o == 8'h00;
  endproperty

  a_cfg_take: assert property (p_cfg_take)
    else $error("option not captured");
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("option changed in run");
  a_run_pins: assert property (p_run_pins)
    else $error("crystal runs without pins");
  a_halt: assert property (p_halt)
    else $error("clock runs in halt");
  a_wdt: assert property (p_wdt)
    else $error("watchdog clock stuck");
  a_rise: assert property (p_rise)
    else $error("short high pulse");
  a_fall: assert property (p_fall)
    else $error("short low pulse");
  a_rdata: assert property (p_rdata)
    else $error("read data outside slot");
endmodule

bind system_oscillator_select osc_select_sva i_sva (
  .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .osc_i(osc_i),
  .fast_rc_cfg_i(fast_rc_cfg_i), .halt_i(halt_i), .rdata_o(rdata_o),
  .clocks_o(clocks_o), .fast_rc_freq_o(fast_rc_freq_o),
  .slow_crystal_run_o(slow_crystal_run_o),
  .slow_crystal_pins_osc_o(slow_crystal_pins_osc_o)
);

// ---- testbench/tb_top.sv ----
// Self-checking bench for the oscillator selector.
// Assumes the design package and checker are compiled first.
`timescale 1ns/1ns

module tb_top;
  import osc_select_pkg::*;
  logic       clk_i, reset_i, ce_i, halt_i, slow_crystal_run_o;
  bus_req_t   bus_i;
  logic [7:0] rdata_o;
  logic [3:0] osc_i = 4'h0;
  logic [1:0] fast_rc_cfg_i, fast_rc_freq_o, slow_crystal_pins_osc_o;
  clk_out_t   clocks_o;
  int         n_fail, n_checks;
  int         h [4] = '{5, 3, 11, 13};
  int         oc [4] = '{default: 0};

  system_oscillator_select #(.STARTUP_CYCLES(20)) i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .osc_i(osc_i), .fast_rc_cfg_i(fast_rc_cfg_i),
    .halt_i(halt_i), .clocks_o(clocks_o), .fast_rc_freq_o(fast_rc_freq_o),
    .slow_crystal_run_o(slow_crystal_run_o),
    .slow_crystal_pins_osc_o(slow_crystal_pins_osc_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Oscillators toggle every h[k] cycles
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (oc[k] == h[k] - 1) begin
        oc[k] <= 0;
        osc_i[k] <= ~osc_i[k];
      end else begin
        oc[k] <= oc[k] + 1;
      end
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    @(posedge clk_i);
    chk(16'(rdata_o), 16'(e));
  endtask

  task automatic lvl(input logic v, inout int c);
    while (clocks_o.sys !== v && c < 3000) begin
      @(posedge clk_i);
      c++;
    end
  endtask

  // Select, then time one full system clock period
  task automatic per(input logic [7:0] ctl, input int e);
    int c;
    c = 0;
    wr(ADDR_SYS_CTRL, ctl);
    repeat (8) @(posedge clk_i);
    lvl(1'b0, c);
    lvl(1'b1, c);
    c = 0;
    lvl(1'b0, c);
    lvl(1'b1, c);
    chk(16'(c), 16'(e));
  endtask

  task automatic t_regs;
    rd(ADDR_SYS_CTRL, 8'h0C);
    chk(16'(fast_rc_freq_o), 16'h0002);
    fast_rc_cfg_i <= 2'h1;
    repeat (2) @(posedge clk_i);
    chk(16'(fast_rc_freq_o), 16'h0002);
    wr(ADDR_FRC_CTRL, 8'h02);
    rd(ADDR_FRC_CTRL, 8'h06);
    wr(ADDR_FRC_CTRL, 8'h01);
    rd(ADDR_FRC_CTRL, 8'h01);
    rd(8'h3A, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_src;
    for (int n = 0; n < 7; n++) begin
      per({n[2:0], 5'h0C}, 6 << n);
    end
    per(8'h04, 10);
    per(8'hEC, 26);
    rd(ADDR_STATUS, 8'h01);
    ce_i <= 1'b0;
    wr(ADDR_PIN_CTRL, 8'h03);
    ce_i <= 1'b1;
    rd(ADDR_PIN_CTRL, 8'h00);
    per(8'hE8, 26);
    wr(ADDR_PIN_CTRL, 8'h03);
    wr(ADDR_SXT_CTRL, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(16'(slow_crystal_run_o), 16'h0001);
    chk(16'(slow_crystal_pins_osc_o), 16'h0003);
    repeat (60) @(posedge clk_i);
    per(8'hE8, 22);
    rd(ADDR_SXT_CTRL, 8'h03);
    wr(ADDR_PIN_CTRL, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(16'(slow_crystal_run_o), 16'h0000);
    per(8'hE8, 26);
    $display("test sources done");
  endtask

  // Sleep first, then idle with both peripheral clocks kept
  task automatic t_halt;
    int s;
    int w;
    int f;
    int u;
    int b;
    for (int m = 0; m < 2; m++) begin
      s = 0;
      w = 0;
      f = 0;
      u = 0;
      b = 0;
      wr(ADDR_SYS_CTRL, {6'h03, m[0], m[0]});
      halt_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      repeat (100) begin
        @(posedge clk_i);
        s += clocks_o.sys;
        w += clocks_o.wdt;
        f += clocks_o.fh;
        u += clocks_o.fsub;
        b += clocks_o.tbase;
      end
      rd(ADDR_STATUS, 8'h08);
      halt_i <= 1'b0;
      chk(16'(s), 16'h0000);
      chk(16'(w != 0), 16'h0001);
      chk(16'(f != 0), 16'(m));
      chk(16'(u != 0), 16'(m));
      chk(16'(b != 0), 16'(m));
      per(8'h0C, 6);
    end
    $display("test halt done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    $display("unexpected at %0t: run timed out", $time);
    finish_test;
  end

  initial begin
    n_fail = 0;
    n_checks = 0;
    reset_i = 1'b1;
    ce_i = 1'b1;
    halt_i = 1'b0;
    bus_i = '0;
    fast_rc_cfg_i = 2'h2;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_src;
    t_halt;
    finish_test;
  end
endmodule
